// File: hw/i2c_slave_pkg.sv
// Shared constants and types for the two-wire serial bus slave.
package i2c_slave_pkg;

   // ------------------------------------------------------------
   // Field widths and bit counts
   // ------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 4;
   // Number of rising clock edges that carry one byte.
   localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;
   // Address field position within the first received byte.
   localparam int ADDR_MSB = 7;
   localparam int ADDR_LSB = 1;
   localparam int DIR_BIT = 0;

   // ------------------------------------------------------------
   // Reserved address groups (upper four bits of the address)
   // ------------------------------------------------------------
   // Two groups of eight give the sixteen reserved addresses.
   localparam int RSV_W = 4;
   localparam logic [RSV_W-1:0] RSV_GROUP_LOW = 4'h0;
   localparam logic [RSV_W-1:0] RSV_GROUP_HIGH = 4'hf;

   // ------------------------------------------------------------
   // Bus clock timing
   // ------------------------------------------------------------
   localparam int MCLK_HZ = 40000000;
   localparam int FASTEST_BPS = 1700000;
   // System clocks per bus bit at the fastest rate, rounded down.
   localparam int MCLK_PER_BIT_MIN = MCLK_HZ / FASTEST_BPS;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic LINE_IDLE_LEVEL = 1'h1;
   localparam logic PULL_RESET = 1'h0;
   localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

   // ------------------------------------------------------------
   // Slave sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_DATA,
      ST_WR_ACK,
      ST_RD_DATA,
      ST_RD_ACK,
      ST_IGNORE
   } slave_state_t;

endpackage

// File: hw/line_events_if.sv
// Synchronised bus line levels and detected bus events.
`timescale 1ns/1ps
interface line_events_if;
   logic scl;
   logic sda;
   logic rise;
   logic fall;
   logic start;
   logic stop;

   modport src (output scl, output sda, output rise, output fall,
      output start, output stop);
   modport dst (input scl, input sda, input rise, input fall,
      input start, input stop);
endinterface

// File: hw/line_sampler.sv
// Two-stage synchroniser and event detector for the clock and data lines.
`timescale 1ns/1ps
module line_sampler
   import i2c_slave_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_sync_n,
   input wire logic scl_in,
   input wire logic sda_in,
   line_events_if.src ev
);

   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] sync;
      logic [1:0] prev;
      logic rise;
      logic fall;
      logic start;
      logic stop;
   } sampler_t;

   sampler_t s_reg;
   sampler_t s_next;

   // The first stage feeds only the second; events compare the settled
   // stage with its previous value, so a metastable sample is never seen.
   always_comb begin
      s_next = s_reg;
      s_next.meta = {scl_in, sda_in};
      s_next.sync = s_reg.meta;
      s_next.prev = s_reg.sync;
      s_next.rise = s_reg.sync[1] & ~s_reg.prev[1];
      s_next.fall = ~s_reg.sync[1] & s_reg.prev[1];
      // Data falling while the clock stays high marks a start.
      s_next.start = s_reg.sync[1] & s_reg.prev[1] & s_reg.prev[0]
         & ~s_reg.sync[0];
      // Data rising while the clock stays high marks a stop.
      s_next.stop = s_reg.sync[1] & s_reg.prev[1] & ~s_reg.prev[0]
         & s_reg.sync[0];
   end

   // Lines reset to their released level so no false event follows reset.
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_reg.meta <= {LINE_IDLE_LEVEL, LINE_IDLE_LEVEL};
         s_reg.sync <= {LINE_IDLE_LEVEL, LINE_IDLE_LEVEL};
         s_reg.prev <= {LINE_IDLE_LEVEL, LINE_IDLE_LEVEL};
         s_reg.rise <= 1'h0;
         s_reg.fall <= 1'h0;
         s_reg.start <= 1'h0;
         s_reg.stop <= 1'h0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ev.scl = s_reg.prev[1];
   assign ev.sda = s_reg.prev[0];
   assign ev.rise = s_reg.rise;
   assign ev.fall = s_reg.fall;
   assign ev.start = s_reg.start;
   assign ev.stop = s_reg.stop;

endmodule

// File: hw/i2c_slave.sv
// Slave end of a two-wire open-drain serial bus with byte user port.
//
// Summary of operation
// - Logic zero pulls the data line low; one releases it, never driven high.
// - Data line changes only while the clock is low, except start/stop.
// - Addressed slave holds data low through the ninth clock high phase.
// - Address and data bytes travel most significant bit first.
// - In a write the slave acknowledges every byte it receives.
// - After direction bit 1 the slave transmits until a master not-acknowledge, stop or start.
// - During a write the slave transmits only the acknowledge bits.
// - A master not-acknowledge returns the slave sequencer to idle.
// - Slave never makes the clock; it only follows it and answers.
// - Reserved address groups are never answered; 112 usable addresses.
`timescale 1ns/1ps
module i2c_slave
   import i2c_slave_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [ADDR_W-1:0] own_addr,
   input wire logic [BYTE_W-1:0] tx_data,
   output logic [BYTE_W-1:0] rx_data,
   output logic rx_valid,
   output logic tx_taken,
   output logic selected,
   output logic read_mode
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------

   // Release is synchronised so every flop past the two-flop reset pipe leaves reset on the same edge.
   logic [1:0] rst_pipe;
   logic rst_sync_n;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'h1};
      end
   end

   assign rst_sync_n = rst_pipe[1];

   // ------------------------------------------------------------
   // Line sampling
   // ------------------------------------------------------------

   line_events_if ev ();

   // Both lines pass three flops before the sequencer reads them.
   line_sampler i_line_sampler (
      .mclk(mclk),
      .rst_sync_n(rst_sync_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .ev(ev)
   );

   // ------------------------------------------------------------
   // Address check
   // ------------------------------------------------------------

   // The two reserved groups leave 112 addresses that may be answered.
   function automatic logic addr_usable(input logic [ADDR_W-1:0] a);
      addr_usable = (a[ADDR_W-1 -: RSV_W] != RSV_GROUP_LOW) &&
         (a[ADDR_W-1 -: RSV_W] != RSV_GROUP_HIGH);
   endfunction

   // ------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------

   typedef struct packed {
      slave_state_t st;
      logic [BYTE_W-1:0] shift;
      logic [CNT_W-1:0] cnt;
      logic rw;
      logic pull;
      logic oe_n;
      logic [BYTE_W-1:0] rx_data;
      logic rx_valid;
      logic tx_taken;
      logic selected;
   } seq_t;

   seq_t q_reg;
   seq_t q_next;

   // Every data-line change is made on a detected clock fall, so the pin
   // moves only while the clock is low; the sync delay gives hold time.
   // The slave never touches the clock line: it has no clock output and
   // does not stretch, which limits it to masters that never wait.
   always_comb begin
      q_next = q_reg;
      q_next.rx_valid = 1'h0;
      q_next.tx_taken = 1'h0;
      if (ev.stop) begin
         q_next.st = ST_IDLE;
         q_next.pull = 1'h0;
         q_next.selected = 1'h0;
      end else if (ev.start) begin
         // A repeated start restarts address reception in any state.
         q_next.st = ST_ADDR;
         q_next.cnt = CNT_RESET;
         q_next.pull = 1'h0;
         q_next.selected = 1'h0;
      end else begin
         case (q_reg.st)
            ST_ADDR: begin
               if (ev.rise) begin
                  q_next.shift = {q_reg.shift[BYTE_W-2:0], ev.sda};
                  q_next.cnt = q_reg.cnt + 4'h1;
               end else if (ev.fall && q_reg.cnt == BITS_PER_BYTE) begin
                  if (q_reg.shift[ADDR_MSB:ADDR_LSB] == own_addr &&
                        addr_usable(own_addr)) begin
                     q_next.rw = q_reg.shift[DIR_BIT];
                     q_next.pull = 1'h1;
                     q_next.selected = 1'h1;
                     q_next.st = ST_ADDR_ACK;
                  end else begin
                     q_next.st = ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               // Acknowledge stays low through the ninth high phase.
               if (ev.fall) begin
                  q_next.cnt = CNT_RESET;
                  if (q_reg.rw) begin
                     q_next.shift = tx_data;
                     q_next.pull = ~tx_data[BYTE_W-1];
                     q_next.tx_taken = 1'h1;
                     q_next.st = ST_RD_DATA;
                  end else begin
                     q_next.pull = 1'h0;
                     q_next.st = ST_WR_DATA;
                  end
               end
            end
            ST_WR_DATA: begin
               if (ev.rise) begin
                  q_next.shift = {q_reg.shift[BYTE_W-2:0], ev.sda};
                  q_next.cnt = q_reg.cnt + 4'h1;
               end else if (ev.fall && q_reg.cnt == BITS_PER_BYTE) begin
                  q_next.rx_data = q_reg.shift;
                  q_next.rx_valid = 1'h1;
                  q_next.pull = 1'h1;
                  q_next.st = ST_WR_ACK;
               end
            end
            ST_WR_ACK: begin
               if (ev.fall) begin
                  q_next.pull = 1'h0;
                  q_next.cnt = CNT_RESET;
                  q_next.st = ST_WR_DATA;
               end
            end
            ST_RD_DATA: begin
               if (ev.rise) begin
                  q_next.cnt = q_reg.cnt + 4'h1;
               end else if (ev.fall) begin
                  if (q_reg.cnt == BITS_PER_BYTE) begin
                     // Release so the master can answer the byte.
                     q_next.pull = 1'h0;
                     q_next.st = ST_RD_ACK;
                  end else begin
                     q_next.shift = {q_reg.shift[BYTE_W-2:0], 1'h0};
                     q_next.pull = ~q_reg.shift[BYTE_W-2];
                  end
               end
            end
            ST_RD_ACK: begin
               if (ev.rise && ev.sda) begin
                  // Not-acknowledge: the master wants no more bytes.
                  q_next.st = ST_IDLE;
                  q_next.selected = 1'h0;
               end else if (ev.fall) begin
                  q_next.shift = tx_data;
                  q_next.pull = ~tx_data[BYTE_W-1];
                  q_next.tx_taken = 1'h1;
                  q_next.cnt = CNT_RESET;
                  q_next.st = ST_RD_DATA;
               end
            end
            default: begin
               // Idle and ignore wait for the next start or stop.
               q_next.pull = 1'h0;
            end
         endcase
      end
      // The enable has a flop of its own so the pin sees no gate.
      q_next.oe_n = ~q_next.pull;
   end

   // The sequencer resets idle with the data line released.
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         q_reg.st <= ST_IDLE;
         q_reg.shift <= BYTE_RESET;
         q_reg.cnt <= CNT_RESET;
         q_reg.rw <= 1'h0;
         q_reg.pull <= PULL_RESET;
         q_reg.oe_n <= ~PULL_RESET;
         q_reg.rx_data <= BYTE_RESET;
         q_reg.rx_valid <= 1'h0;
         q_reg.tx_taken <= 1'h0;
         q_reg.selected <= 1'h0;
      end else begin
         q_reg <= q_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------

   // The pin only ever pulls low; the enable is low while pulling.
   assign sda_out = 1'h0;
   assign sda_oe_n = q_reg.oe_n;
   assign rx_data = q_reg.rx_data;
   assign rx_valid = q_reg.rx_valid;
   assign tx_taken = q_reg.tx_taken;
   assign selected = q_reg.selected;
   assign read_mode = q_reg.rw;

endmodule

// File: tb/i2c_slave_properties.sv
// Port-level checks for the two-wire bus slave.
`timescale 1ns/1ps
module i2c_slave_properties (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic rx_valid,
   input wire logic tx_taken,
   input wire logic selected,
   input wire logic read_mode
);
   // ----
   // Bus conditions at the pins
   // ----
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   sequence start_seq;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   sequence stop_seq;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   // The design sees the pins a few clocks late, so answers get slack.
   pull_only_a: assert property (sda_out == 1'b0)
      else $error("data output value not low");
   low_phase_a: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data pull changed while clock high");
   fall_hold_a: assert property ($fell(scl_in) |-> $stable(sda_oe_n)[*3])
      else $error("data pull changed too soon after clock fall");
   owner_only_a: assert property (!sda_oe_n |-> ##[0:2] selected)
      else $error("data pulled while not addressed");
   sel_ack_a: assert property ($rose(selected) |-> ##[0:2] !sda_oe_n)
      else $error("address accepted without acknowledge");
   rx_pulse_a: assert property (rx_valid |-> selected && !read_mode ##1 !rx_valid)
      else $error("receive pulse outside a write");
   rx_ack_a: assert property (rx_valid |-> ##[0:2] !sda_oe_n)
      else $error("received byte not acknowledged");
   tx_pulse_a: assert property (tx_taken |-> selected && read_mode ##1 !tx_taken)
      else $error("send pulse outside a read");
   stop_drop_a: assert property (stop_seq |-> ##[1:8] !selected)
      else $error("stop did not deselect");
   start_drop_a: assert property (start_seq |-> ##[1:8] !selected)
      else $error("start did not reopen address phase");
endmodule
bind i2c_slave i2c_slave_properties i_i2c_slave_properties (
   .mclk(mclk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .rx_valid(rx_valid),
   .tx_taken(tx_taken), .selected(selected), .read_mode(read_mode));

// File: tb/master_model.sv
// Bus master model that clocks the slave and frames transfers.
`timescale 1ns/1ps
module master_model #(
   parameter int HALF_NS = 400
) (
   output logic scl,
   output logic sda,
   input wire logic sda_bus
);
   // ----
   // Bit and byte framing
   // ----
   // Clock idles high between frames; data moves halfway into low.
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Pins move by non-blocking assignment, so a change that lands on a
   // clock edge is seen by the slave only at the following edge.
   task automatic bit_cycle(input logic b, output logic s);
      #(HALF_NS / 2) sda <= b;
      #(HALF_NS / 2) scl <= 1'b1;
      #(HALF_NS / 2) s = sda_bus;
      #(HALF_NS / 2) scl <= 1'b0;
   endtask
   task automatic start();
      #(HALF_NS / 2) sda <= 1'b1;
      #(HALF_NS / 2) scl <= 1'b1;
      #(HALF_NS) sda <= 1'b0;
      #(HALF_NS) scl <= 1'b0;
   endtask
   task automatic stop();
      #(HALF_NS / 2) sda <= 1'b0;
      #(HALF_NS / 2) scl <= 1'b1;
      #(HALF_NS) sda <= 1'b1;
      #(HALF_NS);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], s);
      end
      bit_cycle(1'b1, s);
      ack = !s;
   endtask
   // A last byte is refused so the slave drops back to idle.
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, s);
         d[i] = s;
      end
      bit_cycle(last, s);
   endtask
endmodule

// File: tb/tb_i2c_bus_transaction.sv
// Self-checking bench for the two-wire bus slave.
`timescale 1ns/1ps
module tb_i2c_bus_transaction;
   import i2c_slave_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] own_addr = 7'h42;
   logic [BYTE_W-1:0] tx_data = 8'h81;
   logic [BYTE_W-1:0] rx_data;
   logic rx_valid, tx_taken, selected, read_mode;
   logic sda_out, sda_oe_n, m_scl, m_sda, ack;
   logic [BYTE_W-1:0] d;
   logic [BYTE_W-1:0] rx_q[$];
   int error_cnt = 0;
   int n_checks = 0;
   // Pull-up wired-AND of both parties on the data line.
   wire sda_bus = m_sda & (sda_oe_n | sda_out);
   always #12.5 mclk = ~mclk;
   i2c_slave i_i2c_slave (.mclk(mclk), .rst_n(rst_n),
      .scl_in(m_scl), .sda_in(sda_bus), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .own_addr(own_addr), .tx_data(tx_data),
      .rx_data(rx_data), .rx_valid(rx_valid), .tx_taken(tx_taken),
      .selected(selected), .read_mode(read_mode));
   master_model i_master_model (.scl(m_scl), .sda(m_sda),
      .sda_bus(sda_bus));
   // ----
   // User side capture and helpers
   // ----
   // Each byte taken is replaced at once, so reads step by 0x11.
   always @(posedge mclk) begin
      if (rx_valid === 1'b1) rx_q.push_back(rx_data);
      if (tx_taken === 1'b1) tx_data <= tx_data + 8'h11;
   end
   task automatic check(input string n, input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_write();
      rx_q = {};
      i_master_model.start();
      i_master_model.wr_byte({7'h42, 1'b0}, ack);
      check("wr_ack", ack, 1'b1);
      check("wr_mode", read_mode, 1'b0);
      i_master_model.wr_byte(8'h5a, ack);
      check("d0_ack", ack, 1'b1);
      i_master_model.wr_byte(8'h01, ack);
      check("d1_ack", ack, 1'b1);
      i_master_model.stop();
      #200;
      check("rx_n", 8'(rx_q.size()), 8'h02);
      check("rx0", rx_q[0], 8'h5a);
      check("rx1", rx_q[1], 8'h01);
      check("wr_sel", selected, 1'b0);
   endtask
   // The user byte still holds its first value here, as no read ran yet.
   task automatic t_read();
      i_master_model.start();
      i_master_model.wr_byte({7'h42, 1'b1}, ack);
      check("rd_ack", ack, 1'b1);
      check("rd_mode", read_mode, 1'b1);
      for (int i = 0; i < 3; i++) begin
         i_master_model.rd_byte(i == 2, d);
         check("rd_data", d, 8'(8'h81 + 8'h11 * i));
      end
      check("nack_sel", selected, 1'b0);
      i_master_model.stop();
   endtask
   // Foreign address is ignored, then a repeated start reaches us.
   task automatic t_nomatch();
      rx_q = {};
      i_master_model.start();
      i_master_model.wr_byte({7'h43, 1'b0}, ack);
      check("nm_ack", ack, 1'b0);
      i_master_model.wr_byte(8'h00, ack);
      check("nm_d_ack", ack, 1'b0);
      i_master_model.start();
      i_master_model.wr_byte({7'h42, 1'b0}, ack);
      check("rs_ack", ack, 1'b1);
      i_master_model.wr_byte(8'hc3, ack);
      i_master_model.stop();
      check("rs_rx", rx_q[0], 8'hc3);
   endtask
   task automatic t_reserved();
      logic [6:0] tbl[4] = '{7'h07, 7'h78, 7'h08, 7'h77};
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk) own_addr <= tbl[i];
         i_master_model.start();
         i_master_model.wr_byte({tbl[i], 1'b0}, ack);
         i_master_model.stop();
         check("rsv_ack", ack, i >= 2);
      end
      @(posedge mclk) own_addr <= 7'h42;
   endtask
   // A stop in mid-byte must drop the partial byte.
   task automatic t_stop_mid();
      rx_q = {};
      i_master_model.start();
      i_master_model.wr_byte({7'h42, 1'b0}, ack);
      for (int i = 0; i < 4; i++) i_master_model.bit_cycle(1'b0, d[0]);
      i_master_model.stop();
      #200;
      check("mid_rx", 8'(rx_q.size()), 8'h00);
      check("mid_sel", selected, 1'b0);
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      check("rst_oe", sda_oe_n, 1'b1);
      rst_n <= 1'b1;
      repeat (12) @(posedge mclk);
      t_write();
      t_read();
      t_nomatch();
      t_reserved();
      t_stop_mid();
      print_verdict();
   end
   // The scenarios need well under half a millisecond of bus time.
   initial begin
      #2000000;
      error_cnt++;
      print_verdict();
   end
endmodule
